// *** iss_pkg.sv ***
// Package with set indices, commands, bit positions and preset values for the status sets
package iss_pkg;

  // ----------------------------------------------------------------
  // Set selection and commands
  // ----------------------------------------------------------------
  localparam int NUM_SETS = 5; // Number of register sets held here

  // Which register set a command addresses
  typedef enum logic [2:0] {
    ISS_SET_DEVICE = 3'h0, // Device status set
    ISS_SET_OPER = 3'h1, // Operation status set
    ISS_SET_CALIB = 3'h2, // Calibrating summary set
    ISS_SET_LOWMISS = 3'h3, // Lower-limit-fail summary set
    ISS_SET_MEAS = 3'h4 // Measuring summary set
  } iss_set_t;

  // Status command kinds, one-hot codes
  typedef enum logic [7:0] {
    ISS_OP_RD_COND = 8'h01, // Read condition, no side effect
    ISS_OP_RD_EVENT = 8'h02, // Read event, clears it
    ISS_OP_RD_ENABLE = 8'h04, // Read enable mask
    ISS_OP_WR_ENABLE = 8'h08, // Write enable mask
    ISS_OP_RD_RISE = 8'h10, // Read rise filter
    ISS_OP_WR_RISE = 8'h20, // Write rise filter
    ISS_OP_RD_FALL = 8'h40, // Read fall filter
    ISS_OP_WR_FALL = 8'h80 // Write fall filter
  } iss_op_t;

  // One command from the text parser
  typedef struct packed {
    iss_op_t op; // Command kind
    iss_set_t set; // Addressed set
    logic [15:0] data; // Write value
  } iss_cmd_t;

  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam logic [15:0] ISS_BIT15_MASK = 16'h7FFF; // Bit 15 always reads zero
  localparam logic [15:0] ISS_ALL_ONES = 16'h7FFF; // Preset all ones in bits 14..0, bit 15 zero
  localparam logic [15:0] ISS_ALL_ZEROS = 16'h0000; // Preset all zeros

  // Device set
  localparam int DEV_PRES_A = 1; // Presence A, B at 1, 2
  localparam int DEV_FAULT_A = 3; // Fault A, B at 3, 4
  localparam int DEV_REAR_A = 5; // Front/rear A, B at 5, 6
  localparam int DEV_PRES_C = 7; // Presence C, D at 7, 8
  localparam int DEV_BATT = 11; // Battery critical
  localparam int DEV_TEMP = 12; // Over temperature
  localparam int DEV_FAN = 13; // Fan failed
  localparam int DEV_KEY = 14; // Front panel key press

  // Operation set
  localparam int OP_CALIB = 0; // Calibrating summary
  localparam int OP_SELFTEST = 1; // Self-test started
  localparam int OP_MEAS = 4; // Measuring summary
  localparam int OP_WAITTRIG = 5; // Waiting for trigger summary
  localparam int OP_SENSE = 10; // Sense summary
  localparam int OP_LOWMISS = 11; // Lower-limit-fail summary
  localparam int OP_HIGHMISS = 12; // Upper-limit-fail summary

  // Sub-sets
  localparam int CAL_CH_A = 1; // Calibrating A..D at 1..4
  localparam int LOW_FIRST = 3; // Lower-limit-fail bits 3..6
  localparam int MEAS_CH_A = 1; // Measuring A, B at 1, 2

endpackage : iss_pkg

// *** iss_status_sets.sv ***
// Status register sets: device, operation and its three summary sub-sets
// What this block does
// - Rise filter reads as 15-bit value
// - Device presence bits 1,2 and 7,8
// - Device bits 3,4 report sensor faults
// - Device bits 5,6 report front/rear connector
// - Presence condition reads one when attached
// - Fall filter bit latches removal event
// - Rise filter bit latches attachment event
// - Device event read clears all event bits
// - Fault on memory failure or dual connection
// - Event bit 14 latches any key press
// - Key bit bypasses filters, condition zero
// - Operation bits 0,1,4,5 summary and selftest
// - Operation bits 10,11,12 sense and limit summaries
// - Bit 15 and unused condition and event bits read zero
// - Calibrating bits 1..4 for channels A..D
// - Calibrating bit set at sequence start
// - Calibrating bit cleared at sequence end
// - Lower-limit-fail bits 3..6 for windows
// - Lower-limit-fail bit set on failed check
// - Limit-fail bit cleared on passing check
// - Measuring bits 1,2 high while measuring
// - Condition read leaves contents unchanged
// - Preset loads enable and filter presets
// - Enable writes keep low 15 bits
`timescale 1ns/10ps
module iss_status_sets
  import iss_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Command port from the text parser
  input wire logic cmd_valid,
  input wire iss_cmd_t cmd,
  input wire logic preset_cmd,
  // Response to the text parser
  output logic rsp_valid_reg,
  output logic [15:0] rsp_data_reg,
  // Sensor and panel pins, asynchronous
  input wire logic usb_option,
  input wire logic [3:0] sensor_present,
  input wire logic [1:0] sensor_rear,
  input wire logic [1:0] sensor_mem_fail,
  input wire logic dual_connect,
  input wire logic key_pressed,
  input wire logic battery_critical,
  input wire logic over_temp,
  input wire logic fan_failed,
  // Measurement engine, same clock
  input wire logic selftest_started,
  input wire logic waiting_trigger,
  input wire logic sense_summary,
  input wire logic high_bound_miss_summary,
  input wire logic [3:0] cal_start,
  input wire logic [3:0] cal_done,
  input wire logic [3:0] low_bound_miss_fail,
  input wire logic [3:0] low_bound_miss_pass,
  input wire logic [1:0] measuring
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Drop bit 15 of any stored or returned value
  function automatic logic [15:0] mask15(input logic [15:0] v);
    mask15 = v & ISS_BIT15_MASK;
  endfunction : mask15

  // Filtered transitions between old and new condition
  function automatic logic [15:0] edges(input logic [15:0] now, input logic [15:0] old,
                                        input logic [15:0] rise, input logic [15:0] fall);
    edges = (rise & now & ~old) | (fall & ~now & old);
  endfunction : edges

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_W = 14; // Width of the pin bundle, one bit per pin

  logic [SYNC_W-1:0] pin_raw; // Pins in one bundle
  logic [SYNC_W-1:0] sync1_reg; // First stage, read only by the second
  logic [SYNC_W-1:0] sync2_reg; // Second stage, safe to use
  logic [SYNC_W-1:0] sync1_next;
  logic [SYNC_W-1:0] sync2_next;
  logic key_old_reg; // Delayed key level for edge detection
  logic key_old_next;

  assign pin_raw = {usb_option, sensor_present, sensor_rear, sensor_mem_fail, dual_connect,
                    key_pressed, battery_critical, over_temp, fan_failed};

  // Shift pins through two stages
  always_comb begin
    sync1_next = pin_raw;
    sync2_next = sync1_reg;
    key_old_next = sync2_reg[3];
  end

  // Register the synchroniser stages
  always_ff @(posedge mclk) begin
    if (reset) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      key_old_reg <= 1'b0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      key_old_reg <= key_old_next;
    end
  end

  // Unpacked synchronised pins
  logic s_usb; // Option fitted, channels C and D exist
  logic [3:0] s_present; // Presence A..D
  logic [1:0] s_rear; // Rear connector A, B
  logic [1:0] s_memfail; // Stored-data memory failure A, B
  logic s_dual; // Sensors on both front and rear
  logic s_key; // Key level
  logic s_batt;
  logic s_temp;
  logic s_fan;
  logic key_edge; // One-cycle key press

  assign {s_usb, s_present, s_rear, s_memfail, s_dual, s_key, s_batt, s_temp, s_fan} = sync2_reg;
  assign key_edge = s_key & ~key_old_reg;

  // ----------------------------------------------------------------
  // Calibration and limit state
  // ----------------------------------------------------------------
  logic [3:0] cal_busy_reg; // Calibration active per channel
  logic [3:0] cal_busy_next;
  logic [3:0] low_miss_reg; // Lower limit failed, per window bit
  logic [3:0] low_miss_next;

  // Start sets, done clears; a start in the same cycle as a done wins
  always_comb begin
    cal_busy_next = (cal_busy_reg & ~cal_done) | cal_start;
    low_miss_next = (low_miss_reg & ~low_bound_miss_pass) | low_bound_miss_fail;
  end

  // Register calibration and limit state
  always_ff @(posedge mclk) begin
    if (reset) begin
      cal_busy_reg <= 4'h0;
      low_miss_reg <= 4'h0;
    end else begin
      cal_busy_reg <= cal_busy_next;
      low_miss_reg <= low_miss_next;
    end
  end

  // ----------------------------------------------------------------
  // Register set storage
  // ----------------------------------------------------------------
  logic [15:0] cond_reg [NUM_SETS]; // Last condition, for edge finding
  logic [15:0] event_reg [NUM_SETS]; // Sticky events
  logic [15:0] enable_reg [NUM_SETS]; // Enable masks
  logic [15:0] rise_reg [NUM_SETS]; // Rise filters
  logic [15:0] fall_reg [NUM_SETS]; // Fall filters
  logic [15:0] cond_now [NUM_SETS]; // Present condition
  logic [15:0] cond_next [NUM_SETS];
  logic [15:0] event_next [NUM_SETS];
  logic [15:0] enable_next [NUM_SETS];
  logic [15:0] rise_next [NUM_SETS];
  logic [15:0] fall_next [NUM_SETS];
  logic rsp_valid_next;
  logic [15:0] rsp_data_next;
  logic [15:0] sel_cond; // Condition of the addressed set
  logic [15:0] sel_event;
  logic [15:0] sel_enable;
  logic [15:0] sel_rise;
  logic [15:0] sel_fall;
  logic set_ok; // Addressed set exists

  // Build the present condition of every set
  always_comb begin
    for (int s = 0; s < NUM_SETS; s++) begin
      cond_now[s] = 16'h0000;
    end
    // Device set; key bit stays zero in the condition
    cond_now[ISS_SET_DEVICE][DEV_PRES_A +: 2] = s_present[1:0];
    cond_now[ISS_SET_DEVICE][DEV_FAULT_A +: 2] = s_memfail | {2{s_dual}};
    cond_now[ISS_SET_DEVICE][DEV_REAR_A +: 2] = s_rear;
    cond_now[ISS_SET_DEVICE][DEV_PRES_C +: 2] = s_present[3:2] & {2{s_usb}};
    cond_now[ISS_SET_DEVICE][DEV_BATT] = s_batt;
    cond_now[ISS_SET_DEVICE][DEV_TEMP] = s_temp;
    cond_now[ISS_SET_DEVICE][DEV_FAN] = s_fan;
    // Calibrating set; C and D only with the option
    cond_now[ISS_SET_CALIB][CAL_CH_A +: 4] = cal_busy_reg & {{2{s_usb}}, 2'b11};
    // Lower-limit-fail set
    cond_now[ISS_SET_LOWMISS][LOW_FIRST +: 4] = low_miss_reg;
    // Measuring set
    cond_now[ISS_SET_MEAS][MEAS_CH_A +: 2] = measuring;
    // Operation set; calibrating, measuring and lower-limit summaries from registered sub-set events
    cond_now[ISS_SET_OPER][OP_CALIB] =
      |(event_reg[ISS_SET_CALIB] & enable_reg[ISS_SET_CALIB]);
    cond_now[ISS_SET_OPER][OP_SELFTEST] = selftest_started;
    cond_now[ISS_SET_OPER][OP_MEAS] =
      |(event_reg[ISS_SET_MEAS] & enable_reg[ISS_SET_MEAS]);
    cond_now[ISS_SET_OPER][OP_WAITTRIG] = waiting_trigger;
    cond_now[ISS_SET_OPER][OP_SENSE] = sense_summary;
    cond_now[ISS_SET_OPER][OP_LOWMISS] =
      |(event_reg[ISS_SET_LOWMISS] & enable_reg[ISS_SET_LOWMISS]);
    cond_now[ISS_SET_OPER][OP_HIGHMISS] = high_bound_miss_summary;
  end

  // Pick the addressed set for the response
  always_comb begin
    set_ok = (cmd.set <= ISS_SET_MEAS);
    sel_cond = 16'h0000;
    sel_event = 16'h0000;
    sel_enable = 16'h0000;
    sel_rise = 16'h0000;
    sel_fall = 16'h0000;
    if (set_ok) begin
      sel_cond = cond_reg[cmd.set];
      sel_event = event_reg[cmd.set];
      sel_enable = enable_reg[cmd.set];
      sel_rise = rise_reg[cmd.set];
      sel_fall = fall_reg[cmd.set];
    end
  end

  // Next values of every set and of the response
  always_comb begin
    rsp_valid_next = 1'b0;
    rsp_data_next = rsp_data_reg;
    for (int s = 0; s < NUM_SETS; s++) begin
      cond_next[s] = mask15(cond_now[s]);
      enable_next[s] = enable_reg[s];
      rise_next[s] = rise_reg[s];
      fall_next[s] = fall_reg[s];
      event_next[s] = event_reg[s];
      // Read of the event register clears it; new events still land
      if (cmd_valid && (cmd.op == ISS_OP_RD_EVENT) && set_ok && (cmd.set == s)) begin
        event_next[s] = 16'h0000;
      end
      event_next[s] = mask15(event_next[s] |
                             edges(cond_now[s], cond_reg[s], rise_reg[s], fall_reg[s]));
      // Preset reloads filters and masks; operation enable goes to zero
      if (preset_cmd) begin
        enable_next[s] = (s == ISS_SET_OPER) ? ISS_ALL_ZEROS : ISS_ALL_ONES;
        rise_next[s] = ISS_ALL_ONES;
        fall_next[s] = ISS_ALL_ZEROS;
      end else if (cmd_valid && set_ok && (cmd.set == s)) begin
        if (cmd.op == ISS_OP_WR_ENABLE) begin
          enable_next[s] = mask15(cmd.data);
        end else if (cmd.op == ISS_OP_WR_RISE) begin
          rise_next[s] = mask15(cmd.data);
        end else if (cmd.op == ISS_OP_WR_FALL) begin
          fall_next[s] = mask15(cmd.data);
        end
      end
    end
    // Key press ignores both filters, sets on the press edge
    if (key_edge) begin
      event_next[ISS_SET_DEVICE][DEV_KEY] = 1'b1;
    end
    // Response; unknown sets answer zero
    if (cmd_valid) begin
      rsp_valid_next = 1'b1;
      case (cmd.op)
        ISS_OP_RD_COND: begin
          rsp_data_next = mask15(sel_cond);
        end
        ISS_OP_RD_EVENT: begin
          rsp_data_next = mask15(sel_event);
        end
        ISS_OP_RD_ENABLE: begin
          rsp_data_next = mask15(sel_enable);
        end
        ISS_OP_RD_RISE: begin
          rsp_data_next = mask15(sel_rise);
        end
        ISS_OP_RD_FALL: begin
          rsp_data_next = mask15(sel_fall);
        end
        default: begin
          // Writes answer with a zero acknowledgement
          rsp_data_next = 16'h0000;
        end
      endcase
    end
  end

  // Register the sets; power-on gives the preset values and clean events
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int s = 0; s < NUM_SETS; s++) begin
        cond_reg[s] <= 16'h0000;
        event_reg[s] <= 16'h0000;
        enable_reg[s] <= (s == ISS_SET_OPER) ? ISS_ALL_ZEROS : ISS_ALL_ONES;
        rise_reg[s] <= ISS_ALL_ONES;
        fall_reg[s] <= ISS_ALL_ZEROS;
      end
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= 16'h0000;
    end else begin
      for (int s = 0; s < NUM_SETS; s++) begin
        cond_reg[s] <= cond_next[s];
        event_reg[s] <= event_next[s];
        enable_reg[s] <= enable_next[s];
        rise_reg[s] <= rise_next[s];
        fall_reg[s] <= fall_next[s];
      end
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg <= rsp_data_next;
    end
  end

endmodule : iss_status_sets

// *** iss_status_sets_props.sv ***
// Checker with the concurrent assertions for the status sets command port
`timescale 1ns/10ps
module iss_status_sets_props
  import iss_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Command and answer
  input wire logic cmd_valid,
  input wire iss_cmd_t cmd,
  input wire logic preset_cmd,
  input wire logic rsp_valid_reg,
  input wire logic [15:0] rsp_data_reg,
  // Engine level
  input wire logic [1:0] measuring
);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  // Write to a real set, not masked by a preset
  sequence s_wr(iss_op_t op);
    cmd_valid && !preset_cmd && cmd.op == op && cmd.set <= ISS_SET_MEAS;
  endsequence
  // Read of the same set on the very next cycle
  sequence s_rd(iss_op_t op);
    cmd_valid && !preset_cmd && cmd.op == op && cmd.set == $past(cmd.set);
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_rsp_follows_cmd: assert property (cmd_valid |=> rsp_valid_reg)
    else $error("answer missing one cycle after a command");
  a_rsp_no_spurious: assert property (!cmd_valid |=> !rsp_valid_reg)
    else $error("answer without a command");
  a_bit15_zero: assert property (rsp_valid_reg |-> rsp_data_reg[15] == 1'b0)
    else $error("bit 15 of an answer is set");
  a_key_cond_zero: assert property (cmd_valid && cmd.op == ISS_OP_RD_COND
    && cmd.set == ISS_SET_DEVICE |=> rsp_data_reg[DEV_KEY] == 1'b0)
    else $error("key bit shows in the device condition");
  a_enable_low_bits: assert property (s_wr(ISS_OP_WR_ENABLE) ##1 s_rd(ISS_OP_RD_ENABLE)
    |=> rsp_data_reg == ($past(cmd.data, 2) & ISS_BIT15_MASK))
    else $error("enable readback differs from the written low bits");
  a_rise_readback: assert property (s_wr(ISS_OP_WR_RISE) ##1 s_rd(ISS_OP_RD_RISE)
    |=> rsp_data_reg == ($past(cmd.data, 2) & ISS_BIT15_MASK))
    else $error("rise filter readback is not the 15-bit value");
  a_preset_oper_en: assert property (preset_cmd ##1 (cmd_valid
    && cmd.op == ISS_OP_RD_ENABLE && cmd.set == ISS_SET_OPER) |=> rsp_data_reg == 16'h0000)
    else $error("operation enable not zero after preset");
  a_meas_cond_track: assert property ($stable(measuring)[*3] ##0 (cmd_valid
    && cmd.op == ISS_OP_RD_COND && cmd.set == ISS_SET_MEAS)
    |=> rsp_data_reg == {13'h0000, $past(measuring), 1'b0})
    else $error("measuring condition does not follow the engine");
  a_bad_set_zero: assert property (cmd_valid && cmd.set > ISS_SET_MEAS
    |=> rsp_data_reg == 16'h0000)
    else $error("unknown set answered non-zero");
endmodule : iss_status_sets_props

// *** iss_host_model.sv ***
// Host model that issues status commands and collects the answers
`timescale 1ns/10ps
module iss_host_model
  import iss_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Command to the block
  output logic cmd_valid,
  output iss_cmd_t cmd,
  // Answer from the block
  input wire logic rsp_valid_reg,
  input wire logic [15:0] rsp_data_reg
);
  // Idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // Answer is taken mid-cycle; a missing answer reads as unknown so it never matches
  task grab(output logic [15:0] r);
    @(negedge mclk);
    if (rsp_valid_reg === 1'b1) r = rsp_data_reg;
    else r = 16'hXXXX;
  endtask : grab
  // One command; released lines show the inverse so stale values cannot pass
  task issue(input iss_cmd_t c, output logic [15:0] r);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd <= c;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    cmd <= ~c;
    grab(r);
  endtask : issue
  // Two commands back to back with no idle cycle
  task issue_pair(input iss_cmd_t c1, input iss_cmd_t c2, output logic [15:0] r2);
    logic [15:0] r1;
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd <= c1;
    @(posedge mclk);
    cmd <= c2;
    grab(r1);
    @(posedge mclk);
    cmd_valid <= 1'b0;
    cmd <= ~c2;
    grab(r2);
  endtask : issue_pair
endmodule : iss_host_model

// *** iss_status_sets_bench.sv ***
// Self-checking bench for the status register sets
`timescale 1ns/10ps
module iss_status_sets_bench;
  import iss_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus signals, all valued at time zero
  // ----------------------------------------------------------------
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid;
  iss_cmd_t cmd;
  logic preset_cmd = 1'b0;
  logic rsp_valid_reg;
  logic [15:0] rsp_data_reg;
  logic usb_option = 1'b0;
  logic [3:0] sensor_present = 4'h0;
  logic [1:0] sensor_rear = 2'h0;
  logic [1:0] sensor_mem_fail = 2'h0;
  logic dual_connect = 1'b0;
  logic key_pressed = 1'b0;
  logic [3:0] eng = 4'h0; // Selftest, trigger wait, sense, upper miss
  logic [3:0] cal_start = 4'h0;
  logic [3:0] cal_done = 4'h0;
  logic [3:0] lo_fail = 4'h0;
  logic [3:0] lo_pass = 4'h0;
  logic [1:0] measuring = 2'h0;
  logic [15:0] junk; // Write answers, not compared; also holds the pair read-backs, which are
  int failures = 0;
  int cmp_count = 0;
  // 10 MHz clock
  always #50 mclk = ~mclk;

  iss_status_sets iss_status_sets_inst (.mclk(mclk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd(cmd), .preset_cmd(preset_cmd), .rsp_valid_reg(rsp_valid_reg),
    .rsp_data_reg(rsp_data_reg), .usb_option(usb_option), .sensor_present(sensor_present),
    .sensor_rear(sensor_rear), .sensor_mem_fail(sensor_mem_fail),
    .dual_connect(dual_connect), .key_pressed(key_pressed), .battery_critical(1'b0),
    .over_temp(1'b0), .fan_failed(1'b0), .selftest_started(eng[0]),
    .waiting_trigger(eng[1]), .sense_summary(eng[2]), .high_bound_miss_summary(eng[3]),
    .cal_start(cal_start), .cal_done(cal_done), .low_bound_miss_fail(lo_fail),
    .low_bound_miss_pass(lo_pass), .measuring(measuring));
  iss_host_model iss_host_model_inst (.mclk(mclk), .cmd_valid(cmd_valid), .cmd(cmd),
    .rsp_valid_reg(rsp_valid_reg), .rsp_data_reg(rsp_data_reg));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  task rd(input iss_op_t op, input iss_set_t s, input logic [15:0] exp);
    logic [15:0] r;
    iss_host_model_inst.issue('{op, s, 16'h0000}, r);
    chk(exp, r);
  endtask : rd
  task wr(input iss_op_t op, input iss_set_t s, input logic [15:0] d);
    iss_host_model_inst.issue('{op, s, d}, junk);
  endtask : wr
  // Pins pass two sync flops and the condition register
  task settle;
    repeat (5) @(posedge mclk);
  endtask : settle
  task done(input string name);
    $display("test %s finished", name);
  endtask : done
  task close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    // Reset values of masks and filters in every set
    for (int i = 0; i < NUM_SETS; i++) begin
      rd(ISS_OP_RD_ENABLE, iss_set_t'(i), (i == 1) ? 16'h0000 : ISS_ALL_ONES);
      rd(ISS_OP_RD_RISE, iss_set_t'(i), ISS_ALL_ONES);
      rd(ISS_OP_RD_FALL, iss_set_t'(i), ISS_ALL_ZEROS);
    end
    iss_host_model_inst.issue_pair('{ISS_OP_WR_ENABLE, ISS_SET_CALIB, 16'hFFFF},
      '{ISS_OP_RD_ENABLE, ISS_SET_CALIB, 16'h0000}, junk);
    chk(16'h7FFF, junk);
    iss_host_model_inst.issue_pair('{ISS_OP_WR_RISE, ISS_SET_DEVICE, 16'h8ABC},
      '{ISS_OP_RD_RISE, ISS_SET_DEVICE, 16'h0000}, junk);
    chk(16'h0ABC, junk);
    wr(ISS_OP_WR_ENABLE, ISS_SET_OPER, 16'h1234);
    wr(ISS_OP_WR_FALL, ISS_SET_DEVICE, 16'h1234);
    // Preset followed at once by a read
    fork
      begin
        @(posedge mclk) preset_cmd <= 1'b1;
        @(posedge mclk) preset_cmd <= 1'b0;
      end
      begin
        @(posedge mclk);
        rd(ISS_OP_RD_ENABLE, ISS_SET_OPER, 16'h0000);
      end
    join
    rd(ISS_OP_RD_FALL, ISS_SET_DEVICE, 16'h0000);
    rd(ISS_OP_RD_RISE, ISS_SET_DEVICE, 16'h7FFF);
    done("masks");
    // Sensor attach and removal
    wr(ISS_OP_WR_FALL, ISS_SET_DEVICE, 16'h0006);
    @(posedge mclk) sensor_present <= 4'h1;
    settle;
    rd(ISS_OP_RD_COND, ISS_SET_DEVICE, 16'h0002);
    rd(ISS_OP_RD_COND, ISS_SET_DEVICE, 16'h0002);
    rd(ISS_OP_RD_EVENT, ISS_SET_DEVICE, 16'h0002);
    rd(ISS_OP_RD_EVENT, ISS_SET_DEVICE, 16'h0000);
    @(posedge mclk) sensor_present <= 4'h0;
    settle;
    rd(ISS_OP_RD_EVENT, ISS_SET_DEVICE, 16'h0002);
    // Channel C stays hidden until the option is fitted
    @(posedge mclk) sensor_present <= 4'h4;
    settle;
    rd(ISS_OP_RD_COND, ISS_SET_DEVICE, 16'h0000);
    @(posedge mclk) usb_option <= 1'b1;
    settle;
    rd(ISS_OP_RD_COND, ISS_SET_DEVICE, 16'h0080);
    done("presence");
    // Faults and connector side
    @(posedge mclk) sensor_mem_fail <= 2'h2;
    settle;
    rd(ISS_OP_RD_COND, ISS_SET_DEVICE, 16'h0090);
    @(posedge mclk) dual_connect <= 1'b1;
    settle;
    rd(ISS_OP_RD_COND, ISS_SET_DEVICE, 16'h0098);
    @(posedge mclk) sensor_rear <= 2'h1;
    settle;
    rd(ISS_OP_RD_COND, ISS_SET_DEVICE, 16'h00B8);
    @(posedge mclk) {sensor_present, sensor_mem_fail, dual_connect, sensor_rear} <= '0;
    settle;
    done("faults");
    // Key press ignores the filters
    wr(ISS_OP_RD_EVENT, ISS_SET_DEVICE, 16'h0000);
    wr(ISS_OP_WR_RISE, ISS_SET_DEVICE, 16'h0000);
    @(posedge mclk) key_pressed <= 1'b1;
    repeat (3) @(posedge mclk);
    key_pressed <= 1'b0;
    settle;
    rd(ISS_OP_RD_COND, ISS_SET_DEVICE, 16'h0000);
    rd(ISS_OP_RD_EVENT, ISS_SET_DEVICE, 16'h4000);
    done("key");
    // Calibration start, end and the operation summary
    @(posedge mclk) cal_start <= 4'h2;
    @(posedge mclk) cal_start <= 4'h0;
    settle;
    rd(ISS_OP_RD_COND, ISS_SET_CALIB, 16'h0004);
    rd(ISS_OP_RD_COND, ISS_SET_OPER, 16'h0001);
    @(posedge mclk) cal_done <= 4'h2;
    @(posedge mclk) cal_done <= 4'h0;
    settle;
    rd(ISS_OP_RD_COND, ISS_SET_CALIB, 16'h0000);
    rd(ISS_OP_RD_EVENT, ISS_SET_CALIB, 16'h0004);
    settle;
    rd(ISS_OP_RD_COND, ISS_SET_OPER, 16'h0000);
    done("calibrating");
    // Lower limit fail and pass
    @(posedge mclk) lo_fail <= 4'h9;
    @(posedge mclk) lo_fail <= 4'h0;
    settle;
    rd(ISS_OP_RD_COND, ISS_SET_LOWMISS, 16'h0048);
    @(posedge mclk) lo_pass <= 4'h1;
    @(posedge mclk) lo_pass <= 4'h0;
    settle;
    rd(ISS_OP_RD_COND, ISS_SET_LOWMISS, 16'h0040);
    rd(ISS_OP_RD_EVENT, ISS_SET_LOWMISS, 16'h0048);
    @(posedge mclk) lo_pass <= 4'h8;
    @(posedge mclk) lo_pass <= 4'h0;
    settle;
    done("limits");
    // Measuring and the remaining operation bits
    @(posedge mclk) measuring <= 2'h1;
    eng <= 4'hF;
    settle;
    rd(ISS_OP_RD_COND, ISS_SET_MEAS, 16'h0002);
    rd(ISS_OP_RD_COND, ISS_SET_OPER, 16'h1432);
    rd(ISS_OP_RD_EVENT, iss_set_t'(3'h5), 16'h0000);
    done("operation");
    close_out();
  end
  // Watchdog, far beyond the expected run of under 2000 cycles
  initial begin
    #1000000;
    failures++;
    close_out();
  end
endmodule : iss_status_sets_bench

bind iss_status_sets iss_status_sets_props iss_status_sets_props_inst (.mclk(mclk),
  .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd), .preset_cmd(preset_cmd),
  .rsp_valid_reg(rsp_valid_reg), .rsp_data_reg(rsp_data_reg), .measuring(measuring));
